// file: hw/arm_card.sv
// Card end: task file and read-multiple command sequencer
`timescale 1ns/100ps
`include "arm_params.svh"
module arm_card
  import arm_pkg::*;
#(
  parameter int SECTOR_WORDS = `ARM_SECTOR_WORDS,
  parameter int SECTORS_PER_TRACK = 63,
  parameter int HEADS = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Task-file link
  arm_tf_if.device tf,
  // Media word requests
  output logic media_rd,
  output logic media_lba_mode,
  output logic [27:0] media_addr,
  // Media answers
  input wire logic media_valid,
  input wire logic [15:0] media_word,
  input wire logic media_unc,
  input wire logic media_corr,
  input wire logic media_idnf
);
  arm_dev_state_type state; // Sequencer state
  logic [7:0] opcode; // Last command written
  logic mult_en; // Multiple mode enabled
  logic bsy, drq, corr, err; // Status flags
  logic unc_flag, idnf_flag, abrt_flag; // Error flags
  logic [8:0] remaining; // Sectors still to move
  logic [8:0] word_cnt; // Words sent in this sector
  logic sec_unc, sec_idnf; // Faults seen in this sector
  logic [3:0] cur_head; // Current sector address
  logic [15:0] cur_cyl;
  logic [7:0] cur_sec;
  logic [3:0] step_head; // Address after the current one
  logic [15:0] step_cyl;
  logic [7:0] step_sec;

  // Decodes used by the sequencer
  wire host_wr = tf.tf_wr && !bsy && !drq;
  wire op_write = host_wr && (tf.tf_sel == `ARM_SEL_OPCODE);
  wire lba_mode = tf.drive_head_select[`ARM_DH_LBA_BIT];
  wire is_read_mult = (opcode == `ARM_OP_READ_MULTIPLE);
  wire is_set_mult = (opcode == `ARM_OP_SET_MULTIPLE);
  wire count_one = (tf.sector_count_byte == `ARM_BLOCK_COUNT_ONE);
  wire count_zero = (tf.sector_count_byte == 8'h00);
  // Zero count means the full 256 sectors
  wire [8:0] start_len = count_zero ? 9'h100 : {1'b0, tf.sector_count_byte};
  wire word_taken = tf.data_valid && tf.data_ready;
  wire last_word = (word_cnt == 9'(SECTOR_WORDS - 1));
  wire sec_bad = sec_unc || sec_idnf;

  // Address successor for the sector walk
  arm_addr_step #(
    .SECTORS_PER_TRACK(SECTORS_PER_TRACK),
    .HEADS(HEADS)
  ) u_step (
    .lba_mode(lba_mode),
    .head(cur_head),
    .cyl(cur_cyl),
    .sec(cur_sec),
    .next_head(step_head),
    .next_cyl(step_cyl),
    .next_sec(step_sec)
  );

  // Status byte: BSY DRDY DWF DSC DRQ CORR IDX ERR
  assign tf.drive_condition = {bsy, 1'b1, 1'b0, 1'b1, drq, corr, 1'b0, err};
  // Error byte: BBK MC MCR TKONF AMNF always zero
  assign tf.fault_report = {1'b0, unc_flag, 1'b0, idnf_flag, 1'b0, abrt_flag, 2'b00};

  // Host writes into the task file while the card is idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tf.sector_count_byte <= 8'h01;
      tf.sector_number_byte <= 8'h01;
      tf.cylinder_low_byte <= 8'h00;
      tf.cylinder_high_byte <= 8'h00;
      tf.drive_head_select <= 8'h00;
      opcode <= 8'h00;
    end else if (host_wr) begin
      case (tf.tf_sel)
        `ARM_SEL_COUNT: tf.sector_count_byte <= tf.tf_wdata;
        `ARM_SEL_SECNUM: tf.sector_number_byte <= tf.tf_wdata;
        `ARM_SEL_CYL_LOW: tf.cylinder_low_byte <= tf.tf_wdata;
        `ARM_SEL_CYL_HIGH: tf.cylinder_high_byte <= tf.tf_wdata;
        `ARM_SEL_DRV_HEAD: tf.drive_head_select <= tf.tf_wdata;
        `ARM_SEL_OPCODE: opcode <= tf.tf_wdata;
        default: begin
          // Feature byte is not used by this command
        end
      endcase
    end else if (state == ARM_DEV_SECTOR_END) begin
      if (sec_bad) begin
        tf.sector_count_byte <= remaining[7:0];
      end else begin
        // Last good sector becomes visible in the task file
        tf.sector_number_byte <= cur_sec;
        tf.cylinder_low_byte <= cur_cyl[7:0];
        tf.cylinder_high_byte <= cur_cyl[15:8];
        tf.drive_head_select <= {tf.drive_head_select[7:4], cur_head};
        tf.sector_count_byte <= 8'(remaining - 9'h001);
      end
    end
  end

  // Command sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ARM_DEV_IDLE;
      mult_en <= 1'b0;
      bsy <= 1'b0;
      drq <= 1'b0;
      corr <= 1'b0;
      err <= 1'b0;
      unc_flag <= 1'b0;
      idnf_flag <= 1'b0;
      abrt_flag <= 1'b0;
      remaining <= 9'h000;
      word_cnt <= 9'h000;
      sec_unc <= 1'b0;
      sec_idnf <= 1'b0;
      cur_head <= 4'h0;
      cur_cyl <= 16'h0000;
      cur_sec <= 8'h00;
      media_rd <= 1'b0;
      tf.data_valid <= 1'b0;
      tf.data_word <= 16'h0000;
    end else begin
      media_rd <= 1'b0;
      case (state)
        ARM_DEV_IDLE: begin
          // Opcode write starts a command and clears old outcome
          if (op_write) begin
            bsy <= 1'b1;
            corr <= 1'b0;
            err <= 1'b0;
            unc_flag <= 1'b0;
            idnf_flag <= 1'b0;
            abrt_flag <= 1'b0;
            state <= ARM_DEV_DECODE;
          end
        end
        ARM_DEV_DECODE: begin
          // Start address taken from the task file
          cur_head <= tf.drive_head_select[3:0];
          cur_cyl <= {tf.cylinder_high_byte, tf.cylinder_low_byte};
          cur_sec <= tf.sector_number_byte;
          remaining <= start_len;
          word_cnt <= 9'h000;
          if (is_read_mult && mult_en) begin
            state <= ARM_DEV_WORD_REQ;
          end else if (is_set_mult && (count_one || count_zero)) begin
            // Zero disables, one enables; larger blocks are refused
            mult_en <= count_one;
            bsy <= 1'b0;
            state <= ARM_DEV_IDLE;
          end else begin
            // Refused command ends with no data moved
            if (is_set_mult) begin
              mult_en <= 1'b0;
            end
            abrt_flag <= 1'b1;
            err <= 1'b1;
            bsy <= 1'b0;
            state <= ARM_DEV_IDLE;
          end
        end
        ARM_DEV_WORD_REQ: begin
          // Ask the media for the next word
          media_rd <= 1'b1;
          state <= ARM_DEV_WORD_WAIT;
        end
        ARM_DEV_WORD_WAIT: begin
          if (media_valid) begin
            tf.data_word <= media_word;
            tf.data_valid <= 1'b1;
            // Block stays open for the whole sector, no pause between words
            bsy <= 1'b0;
            drq <= 1'b1;
            if (media_unc) begin
              sec_unc <= 1'b1;
            end
            if (media_idnf) begin
              sec_idnf <= 1'b1;
            end
            if (media_corr) begin
              corr <= 1'b1;
            end
            state <= ARM_DEV_WORD_HAND;
          end
        end
        ARM_DEV_WORD_HAND: begin
          // Word held until the controller takes it
          if (word_taken) begin
            tf.data_valid <= 1'b0;
            if (last_word) begin
              // Block count is one, so each sector closes a block
              drq <= 1'b0;
              bsy <= 1'b1;
              state <= ARM_DEV_SECTOR_END;
            end else begin
              word_cnt <= word_cnt + 9'h001;
              state <= ARM_DEV_WORD_REQ;
            end
          end
        end
        ARM_DEV_SECTOR_END: begin
          word_cnt <= 9'h000;
          sec_unc <= 1'b0;
          sec_idnf <= 1'b0;
          if (sec_bad) begin
            // Unrecoverable sector ends the command
            unc_flag <= sec_unc;
            idnf_flag <= sec_idnf;
            err <= 1'b1;
            bsy <= 1'b0;
            state <= ARM_DEV_IDLE;
          end else begin
            cur_head <= step_head;
            cur_cyl <= step_cyl;
            cur_sec <= step_sec;
            remaining <= remaining - 9'h001;
            if (remaining == 9'h001) begin
              bsy <= 1'b0;
              state <= ARM_DEV_IDLE;
            end else begin
              state <= ARM_DEV_WORD_REQ;
            end
          end
        end
        default: begin
          state <= ARM_DEV_IDLE;
        end
      endcase
    end
  end

  // Media address follows the sector in progress
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      media_addr <= 28'h000_0000;
      media_lba_mode <= 1'b0;
    end else begin
      media_addr <= {cur_head, cur_cyl, cur_sec};
      media_lba_mode <= lba_mode;
    end
  end
endmodule // arm_card

// file: hw/arm_params.svh
// Constants for the read-multiple task-file command block and its controller
`ifndef ARM_PARAMS_SVH
`define ARM_PARAMS_SVH

// Task-file register selects
`define ARM_SEL_FEATURE 3'h1
`define ARM_SEL_COUNT 3'h2
`define ARM_SEL_SECNUM 3'h3
`define ARM_SEL_CYL_LOW 3'h4
`define ARM_SEL_CYL_HIGH 3'h5
`define ARM_SEL_DRV_HEAD 3'h6
`define ARM_SEL_OPCODE 3'h7

// Opcodes
`define ARM_OP_READ_MULTIPLE 8'hC4
`define ARM_OP_SET_MULTIPLE 8'hC6

// Only block count that enables multiple mode
`define ARM_BLOCK_COUNT_ONE 8'h01

// Drive/head field positions
`define ARM_DH_LBA_BIT 6
`define ARM_DH_DRIVE_BIT 4

// Error register bit positions
`define ARM_ERR_UNC_BIT 6
`define ARM_ERR_IDNF_BIT 4
`define ARM_ERR_ABRT_BIT 2

// Words in one sector
`define ARM_SECTOR_WORDS 256

// Controller register offsets
`define ARM_REG_CTRL 8'h00
`define ARM_REG_ADDR 8'h04
`define ARM_REG_COUNT 8'h08
`define ARM_REG_RESULT 8'h0C
`define ARM_REG_LAST 8'h10
`define ARM_REG_IRQ_STAT 8'h14
`define ARM_REG_IRQ_MASK 8'h18

// Controller control bits and interrupt bits
`define ARM_CTRL_READ_BIT 0
`define ARM_CTRL_SETMULT_BIT 1
`define ARM_IRQ_DONE_BIT 0
`define ARM_IRQ_ERROR_BIT 1

// Reset values
`define ARM_RESET_ADDR 32'h0000_0000
`define ARM_RESET_COUNT 32'h0000_0101
`define ARM_RESET_MASK 2'h0

// AXI responses
`define ARM_RESP_OKAY 2'h0
`define ARM_RESP_SLVERR 2'h2

`endif

// file: hw/arm_pkg.sv
// Types shared by both ends of the read-multiple block
package arm_pkg;
  // Device command sequencer
  typedef enum logic [2:0] {
    ARM_DEV_IDLE,
    ARM_DEV_DECODE,
    ARM_DEV_WORD_REQ,
    ARM_DEV_WORD_WAIT,
    ARM_DEV_WORD_HAND,
    ARM_DEV_SECTOR_END
  } arm_dev_state_type;

  // Controller sequencer
  typedef enum logic [1:0] {
    ARM_HOST_IDLE,
    ARM_HOST_LOAD,
    ARM_HOST_SETTLE,
    ARM_HOST_WAIT
  } arm_host_state_type;
endpackage

// file: hw/arm_tf_if.sv
// Task-file link between the controller and the card
`timescale 1ns/100ps
interface arm_tf_if;
  // Task-file writes from the controller
  logic tf_wr;
  logic [2:0] tf_sel;
  logic [7:0] tf_wdata;
  // Task-file contents shown by the card
  logic [7:0] drive_condition;
  logic [7:0] fault_report;
  logic [7:0] sector_count_byte;
  logic [7:0] sector_number_byte;
  logic [7:0] cylinder_low_byte;
  logic [7:0] cylinder_high_byte;
  logic [7:0] drive_head_select;
  // Data words toward the controller
  logic [15:0] data_word;
  logic data_valid;
  logic data_ready;

  modport device (
    input tf_wr, tf_sel, tf_wdata, data_ready,
    output drive_condition, fault_report, sector_count_byte, sector_number_byte,
    output cylinder_low_byte, cylinder_high_byte, drive_head_select, data_word, data_valid
  );
  modport host (
    output tf_wr, tf_sel, tf_wdata, data_ready,
    input drive_condition, fault_report, sector_count_byte, sector_number_byte,
    input cylinder_low_byte, cylinder_high_byte, drive_head_select, data_word, data_valid
  );
endinterface

// file: hw/arm_addr_step.sv
// Next sector address in CHS or LBA form
`timescale 1ns/100ps
module arm_addr_step #(
  parameter int SECTORS_PER_TRACK = 63,
  parameter int HEADS = 16
) (
  // Current address
  input wire logic lba_mode,
  input wire logic [3:0] head,
  input wire logic [15:0] cyl,
  input wire logic [7:0] sec,
  // Following address
  output logic [3:0] next_head,
  output logic [15:0] next_cyl,
  output logic [7:0] next_sec
);
  // LBA view of the address and its successor
  wire [27:0] lba = {head, cyl, sec};
  wire [27:0] lba_inc = lba + 28'h000_0001;
  // CHS wrap points
  wire sec_wrap = (sec == 8'(SECTORS_PER_TRACK));
  wire head_wrap = (head == 4'(HEADS - 1));
  wire [3:0] chs_head = sec_wrap ? (head_wrap ? 4'h0 : head + 4'h1) : head;
  wire [15:0] chs_cyl = (sec_wrap && head_wrap) ? cyl + 16'h0001 : cyl;
  wire [7:0] chs_sec = sec_wrap ? 8'h01 : sec + 8'h01;

  // Pick form by mode
  assign next_head = lba_mode ? lba_inc[27:24] : chs_head;
  assign next_cyl = lba_mode ? lba_inc[23:8] : chs_cyl;
  assign next_sec = lba_mode ? lba_inc[7:0] : chs_sec;
endmodule // arm_addr_step

// file: hw/arm_host.sv
// Controller end: AXI4-Lite registers driving the task file
`timescale 1ns/100ps
`include "arm_params.svh"
module arm_host
  import arm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Received words and interrupt
  output logic [15:0] rx_word,
  output logic rx_valid,
  output logic irq,
  // Task-file link
  arm_tf_if.host tf
);
  arm_host_state_type state; // Sequencer state
  logic [31:0] addr_reg, count_reg; // Software settings
  logic [1:0] irq_stat, irq_mask; // Sticky events and mask
  logic set_mult; // Current order is set multiple
  logic [2:0] step; // Task-file register being loaded
  logic [7:0] aw_addr; // Captured write address
  logic [31:0] w_data; // Captured write data
  logic aw_have, w_have; // Halves of a write held

  // Write decode once both halves are in
  wire wr_fire = aw_have && w_have && !s_axi_bvalid;
  wire ctrl_wr = wr_fire && (aw_addr == `ARM_REG_CTRL) && (state == ARM_HOST_IDLE);
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire busy = (state != ARM_HOST_IDLE);
  wire done_now = (state == ARM_HOST_WAIT) && !tf.drive_condition[7] && !tf.drive_condition[3];
  wire stat_rd = rd_fire && (s_axi_araddr == `ARM_REG_IRQ_STAT);
  // Task-file byte for each load step
  wire [7:0] load_byte = (step == `ARM_SEL_COUNT) ? (set_mult ? count_reg[15:8] : count_reg[7:0]) :
    (step == `ARM_SEL_SECNUM) ? addr_reg[7:0] :
    (step == `ARM_SEL_CYL_LOW) ? addr_reg[15:8] :
    (step == `ARM_SEL_CYL_HIGH) ? addr_reg[23:16] :
    (step == `ARM_SEL_DRV_HEAD) ? {1'b1, addr_reg[28], 1'b1, addr_reg[29], addr_reg[27:24]} :
    (set_mult ? `ARM_OP_SET_MULTIPLE : `ARM_OP_READ_MULTIPLE);
  // Event bits for the interrupt status
  wire [1:0] events = {done_now && tf.drive_condition[0], done_now};
  // Read data mux
  wire [31:0] rd_mux = (s_axi_araddr == `ARM_REG_CTRL) ? {31'h0, busy} :
    (s_axi_araddr == `ARM_REG_ADDR) ? addr_reg :
    (s_axi_araddr == `ARM_REG_COUNT) ? count_reg :
    (s_axi_araddr == `ARM_REG_RESULT) ?
      {8'h00, tf.sector_count_byte, tf.fault_report, tf.drive_condition} :
    (s_axi_araddr == `ARM_REG_LAST) ? {4'h0, tf.drive_head_select[3:0],
      tf.cylinder_high_byte, tf.cylinder_low_byte, tf.sector_number_byte} :
    (s_axi_araddr == `ARM_REG_IRQ_STAT) ? {30'h0, irq_stat} :
    (s_axi_araddr == `ARM_REG_IRQ_MASK) ? {30'h0, irq_mask} : 32'h0000_0000;
  wire rd_ok = (s_axi_araddr <= `ARM_REG_IRQ_MASK) && (s_axi_araddr[1:0] == 2'b00);

  // Write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ARM_RESP_OKAY;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_awready;
      s_axi_wready <= !w_have && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > `ARM_REG_IRQ_MASK) ? `ARM_RESP_SLVERR : `ARM_RESP_OKAY;
      end else if (s_axi_bready) begin
        // Response taken, free for the next write
        s_axi_bvalid <= 1'b0;
        if (s_axi_bvalid) begin
          aw_have <= 1'b0;
          w_have <= 1'b0;
        end
      end
    end
  end

  // Read channel, answers one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ARM_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
        (!s_axi_rvalid && !rd_fire);
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `ARM_RESP_OKAY : `ARM_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Settings registers and interrupt status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_reg <= `ARM_RESET_ADDR;
      count_reg <= `ARM_RESET_COUNT;
      irq_mask <= `ARM_RESET_MASK;
      irq_stat <= 2'h0;
      irq <= 1'b0;
    end else begin
      if (wr_fire && (aw_addr == `ARM_REG_ADDR)) begin
        addr_reg <= w_data;
      end
      if (wr_fire && (aw_addr == `ARM_REG_COUNT)) begin
        count_reg <= w_data;
      end
      if (wr_fire && (aw_addr == `ARM_REG_IRQ_MASK)) begin
        irq_mask <= w_data[1:0];
      end
      // New event wins over the clearing read
      irq_stat <= (stat_rd ? 2'h0 : irq_stat) | events;
      irq <= |(((stat_rd ? 2'h0 : irq_stat) | events) & irq_mask);
    end
  end

  // Command sequencer: load task file, then collect data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ARM_HOST_IDLE;
      set_mult <= 1'b0;
      step <= `ARM_SEL_COUNT;
      tf.tf_wr <= 1'b0;
      tf.tf_sel <= 3'h0;
      tf.tf_wdata <= 8'h00;
      tf.data_ready <= 1'b0;
      rx_word <= 16'h0000;
      rx_valid <= 1'b0;
    end else begin
      tf.tf_wr <= 1'b0;
      rx_valid <= 1'b0;
      case (state)
        ARM_HOST_IDLE: begin
          if (ctrl_wr && (w_data[`ARM_CTRL_READ_BIT] || w_data[`ARM_CTRL_SETMULT_BIT])) begin
            set_mult <= w_data[`ARM_CTRL_SETMULT_BIT];
            step <= `ARM_SEL_COUNT;
            state <= ARM_HOST_LOAD;
          end
        end
        ARM_HOST_LOAD: begin
          // One task-file byte per cycle, opcode last
          tf.tf_wr <= 1'b1;
          tf.tf_sel <= step;
          tf.tf_wdata <= load_byte;
          if (step == `ARM_SEL_OPCODE) begin
            state <= ARM_HOST_SETTLE;
          end else begin
            step <= step + 3'h1;
          end
        end
        ARM_HOST_SETTLE: begin
          // Gives the card time to raise busy
          tf.data_ready <= 1'b1;
          state <= ARM_HOST_WAIT;
        end
        ARM_HOST_WAIT: begin
          if (tf.data_valid && tf.data_ready) begin
            rx_word <= tf.data_word;
            rx_valid <= 1'b1;
          end
          if (done_now) begin
            tf.data_ready <= 1'b0;
            state <= ARM_HOST_IDLE;
          end
        end
        default: begin
          state <= ARM_HOST_IDLE;
        end
      endcase
    end
  end
endmodule // arm_host

// file: dv/arm_tf_asserts.sv
// Checks on the task-file link
`timescale 1ns/100ps
`include "arm_params.svh"
module arm_tf_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link signals
  input wire logic tf_wr,
  input wire logic [2:0] tf_sel,
  input wire logic [7:0] tf_wdata,
  input wire logic [7:0] drive_condition,
  input wire logic [7:0] fault_report,
  input wire logic [7:0] sector_count_byte,
  input wire logic data_valid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire bsy = drive_condition[7]; // Busy
  wire drq = drive_condition[3]; // Data request
  wire idle = !bsy && !drq; // Writes are taken
  wire op_wr = tf_wr && idle && tf_sel == `ARM_SEL_OPCODE;
  wire rd_op = op_wr && tf_wdata == `ARM_OP_READ_MULTIPLE;
  wire set_op = op_wr && tf_wdata == `ARM_OP_SET_MULTIPLE;
  logic en; // Block count of one in force
  logic run; // Accepted read still open
  wire done = run && idle; // Accepted read ended
  // Mirror of mode and read state; only a count of one enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en <= 1'b0;
      run <= 1'b0;
    end else begin
      en <= set_op ? (sector_count_byte == 8'h01) : en;
      run <= (rd_op && en) || (run && !idle);
    end
  end
  // Refused read: idle with abort and error flagged
  sequence abort_end;
    idle && fault_report[`ARM_ERR_ABRT_BIT] && drive_condition[0];
  endsequence
  fixed_bits_a: assert property (idle |-> drive_condition[6:4] == 3'h5 && !drive_condition[1])
    else $error("Status fixed bits wrong");
  err_flag_a: assert property (idle |-> drive_condition[0] == |fault_report)
    else $error("Error flag disagrees with error bits");
  err_zero_a: assert property ((fault_report & 8'hAB) == 8'h00)
    else $error("Fixed error bits set");
  read_busy_a: assert property (rd_op |=> bsy)
    else $error("Read opcode not taken");
  read_abort_a: assert property (rd_op && !en |-> ##2 abort_end)
    else $error("Read without mode not aborted");
  abort_nodata_a: assert property (rd_op && !en |=> !data_valid [*3])
    else $error("Data moved on refused read");
  drq_block_a: assert property ($rose(drq) |-> drq [*8])
    else $error("Request dropped inside sector");
  data_drq_a: assert property (data_valid |-> drq)
    else $error("Word offered without request");
  done_count_a: assert property (done && !drive_condition[0] |-> sector_count_byte == 8'h00)
    else $error("Count not zero after clean read");
  done_noabort_a: assert property (done |-> !fault_report[`ARM_ERR_ABRT_BIT])
    else $error("Abort bit after accepted read");
endmodule // arm_tf_asserts

// file: dv/ata_read_multiple_cmd_tb.sv
// Bench for the read-multiple controller and card
`timescale 1ns/100ps
`include "arm_params.svh"
module ata_read_multiple_cmd_tb;
  logic aclk = 1'b0; // 25 MHz
  logic aresetn = 1'b0; // Held low at start
  // AXI side
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, rx_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] rx_word, media_word = 16'h0;
  // Media side
  logic media_rd, media_lba_mode, media_valid = 1'b0, media_unc = 1'b0, media_idnf = 1'b0;
  logic media_corr = 1'b0; // Corrected-data flag toward the card
  logic [27:0] media_addr; // Sector the card is reading
  logic [1:0] bad = 2'h0; // Fault to inject
  logic [15:0] exp_q[$]; // Words owed to the host
  int failures = 0, cmp_count = 0, rx_n = 0;
  arm_tf_if tf_link();
  arm_host i_arm_host(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_word, .rx_valid, .irq,
    .tf(tf_link.host));
  // Short sectors keep the run brief
  arm_card #(.SECTOR_WORDS(8)) i_arm_card(.aclk, .aresetn, .tf(tf_link.device), .media_rd,
    .media_lba_mode, .media_addr, .media_valid, .media_word, .media_unc,
    .media_corr, .media_idnf);
  arm_tf_asserts i_arm_tf_asserts(.aclk, .aresetn, .tf_wr(tf_link.tf_wr),
    .tf_sel(tf_link.tf_sel), .tf_wdata(tf_link.tf_wdata),
    .drive_condition(tf_link.drive_condition), .fault_report(tf_link.fault_report),
    .sector_count_byte(tf_link.sector_count_byte), .data_valid(tf_link.data_valid));
  // Clock
  initial forever #20 aclk = ~aclk;
  // Media answers a cycle after each request; word bus churns otherwise
  always @(posedge aclk) begin
    media_valid <= media_rd;
    media_word <= 16'($urandom);
    media_unc <= bad[0];
    media_idnf <= bad[1];
    media_corr <= bad[1];
    if (media_valid) exp_q.push_back(media_word);
  end
  // Each received word against the oldest owed
  always @(posedge aclk) begin
    if (rx_valid) begin
      rx_n++;
      chk({16'h0, rx_word}, {16'h0, exp_q.size() > 0 ? exp_q.pop_front() : ~rx_word});
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write with both halves offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, `ARM_RESP_OKAY});
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d & m, e);
  endtask
  // Start a command, wait for its interrupt, clear it
  task automatic run(input logic [31:0] ctrl, input logic [31:0] stat);
    // A missing interrupt hangs here and the watchdog ends the run
    axw(`ARM_REG_CTRL, ctrl);
    while (!irq) begin
      @(posedge aclk);
    end
    rchk(`ARM_REG_IRQ_STAT, 32'hFFFF_FFFF, stat);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic end_sim();
    $display("Compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    repeat (40000) @(posedge aclk);
    failures++;
    end_sim();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(32'hFB22D5C9));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`ARM_REG_RESULT, 32'hFFFF_FFFF, 32'h0001_0050);
    axw(`ARM_REG_IRQ_MASK, 32'h3);
    run(32'h1, 32'h3);
    rchk(`ARM_REG_RESULT, 32'hFFFF, 32'h0451);
    $display("Test 1 done");
    axw(`ARM_REG_COUNT, 32'h0201);
    run(32'h2, 32'h3);
    run(32'h1, 32'h3);
    chk(rx_n, 0);
    $display("Test 2 done");
    axw(`ARM_REG_COUNT, 32'h0101);
    run(32'h2, 32'h1);
    axw(`ARM_REG_ADDR, 32'h1312_34FF);
    axw(`ARM_REG_COUNT, 32'h0102);
    run(32'h1, 32'h1);
    chk(rx_n, 16);
    rchk(`ARM_REG_RESULT, 32'hFFFF_FFFF, 32'h0000_0050);
    rchk(`ARM_REG_LAST, 32'hFFFF_FFFF, 32'h0312_3500);
    $display("Test 3 done");
    for (int k = 1; k < 3; k++) begin
      bad <= 2'(k);
      // LBA form on the first pass, CHS form on the second
      axw(`ARM_REG_ADDR, {3'h0, k == 1, 28'h000_0010});
      axw(`ARM_REG_COUNT, 32'h0101);
      run(32'h1, 32'h3);
      bad <= 2'h0;
      chk(rx_n, 16 + 8 * k);
      chk({3'h0, media_lba_mode, media_addr}, {3'h0, k == 1, 28'h000_0010});
      rchk(`ARM_REG_RESULT, 32'hFFFF_FFFF, {16'h0001, k == 1 ? 16'h4051 : 16'h1055});
      rchk(`ARM_REG_LAST, 32'hFFFF_FFFF, 32'h0000_0010);
    end
    $display("Test 4 done");
    // Block count of zero turns multiple mode off again
    axw(`ARM_REG_COUNT, 32'h0001);
    run(32'h2, 32'h1);
    run(32'h1, 32'h3);
    axr(8'h1C, d, r);
    chk({d[29:0], r}, {30'h0, `ARM_RESP_SLVERR});
    $display("Test 5 done");
    end_sim();
  end
endmodule // ata_read_multiple_cmd_tb
